// file: verification/dca_mod_model.sv
// Pair of first-order sigma-delta modulators driving the angle core inputs.
// Assumes levels are signed, 32767 being an all-ones stream, -32768 all zeros.
`timescale 1ns/1ns
`default_nettype none
module dca_mod_model (
	// Modulator clock from the core
	input  wire logic               mod_clk,
	// Levels to encode
	input  wire logic signed [15:0] sin_lvl,
	input  wire logic signed [15:0] cos_lvl,
	// Bit streams
	output logic                    sin_bit,
	output logic                    cos_bit
);
	int acc_s = 0;
	int acc_c = 0;

	// Idle bits before the first clock
	initial begin
		sin_bit = 1'b0;
		cos_bit = 1'b1;
	end

	// One bit a period, changed just after the falling edge, far from the sampling edge
	always @(negedge mod_clk) begin
		#2;
		sin_bit <= (acc_s >= 0);
		cos_bit <= (acc_c >= 0);
		acc_s += int'(sin_lvl) - ((acc_s >= 0) ? 32767 : -32768);
		acc_c += int'(cos_lvl) - ((acc_c >= 0) ? 32767 : -32768);
	end
endmodule
`default_nettype wire

// file: verification/dual_decimation_cordic_angle_bench.sv
// Self-checking bench for the dual decimation and angle core.
// Assumes the modulator model file is compiled first.
`timescale 1ns/1ns
`default_nettype none
module dual_decimation_cordic_angle_bench;
	logic               clk_sys;
	logic               arst_n;
	logic signed [15:0] sin_lvl;
	logic signed [15:0] cos_lvl;
	logic               sin_bit;
	logic               cos_bit;
	logic               mod_clk;
	logic [12:0]        dac_code;
	logic               dac_load;
	logic [12:0]        tobs;
	logic               lost_signal;
	int                 bad_count = 0;
	int                 checks_done = 0;
	int                 cyc = 0;
	int                 t_load = 0;
	int                 gap = 0;

	dca_top #(.RESP_MAX_CYC(60000), .LOST_MAG_TH(18'h00100)) dut (
		.clk_sys                 (clk_sys),
		.arst_n                  (arst_n),
		.sin_bit                 (sin_bit),
		.cos_bit                 (cos_bit),
		.mod_clk                 (mod_clk),
		.dac_code                (dac_code),
		.dac_load                (dac_load),
		.test_observation_output (tobs),
		.lost_signal             (lost_signal)
	);

	dca_mod_model modl (
		.mod_clk (mod_clk),
		.sin_lvl (sin_lvl),
		.cos_lvl (cos_lvl),
		.sin_bit (sin_bit),
		.cos_bit (cos_bit)
	);

	// 50 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Cycle counter
	always @(posedge clk_sys) cyc <= cyc + 1;

	// Compare within a tolerance; an unknown never matches
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp,
		input int tol);
		logic ok;
		ok = ({1'b0, seen} + 17'(tol) >= {1'b0, exp}) && ({1'b0, seen} <= {1'b0, exp} + 17'(tol));
		checks_done++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("ERROR %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	// Closing report
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Wait for the next load pulse, note its spacing, check its width
	task automatic wait_load();
		int n;
		for (n = 0; n < 13500; n++) begin
			@(negedge clk_sys);
			if (dac_load === 1'b1) break;
		end
		if (n == 13500) begin
			bad_count++;
			$display("ERROR dac_load expected 1 seen 0");
			give_verdict();
		end
		gap = cyc - t_load;
		t_load = cyc;
		@(negedge clk_sys);
		chk("dac_load width", 16'(dac_load), 16'h0000, 0);
	endtask

	// Put a new angle on both channels
	task automatic set_angle(input real deg);
		@(posedge clk_sys);
		#2;
		sin_lvl = 16'(int'(20000.0 * $sin(deg * 3.14159265 / 180.0)));
		cos_lvl = 16'(int'(20000.0 * $cos(deg * 3.14159265 / 180.0)));
	endtask

	// Expected output code of an angle in degrees
	function automatic int exp_code(input real deg);
		return 410 + ((int'(deg * 8192.0 / 360.0) * 7372) >> 13);
	endfunction

	// Judge angle word, code and lost flag after a load
	task automatic check_out(input real deg);
		chk("test_observation_output", 16'(tobs), 16'(int'(deg * 8192.0 / 360.0)), 12);
		chk("dac_code", 16'(dac_code), 16'(exp_code(deg)), 12);
		chk("lost_signal", 16'(lost_signal), 16'h0000, 0);
	endtask

	// Reset state, then modulator clock shape
	task automatic test_reset_clock();
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		@(negedge clk_sys);
		chk("reset dac_code", 16'(dac_code), 16'h0000, 0);
		chk("reset mod_clk", 16'(mod_clk), 16'h0000, 0);
		repeat (2) @(posedge clk_sys);
		#2;
		arst_n = 1'b1;
		for (int i = 0; i < 20 && mod_clk !== 1'b1; i++) @(negedge clk_sys);
		// First high phase after reset is one cycle short, so time the next full period
		for (int i = 0; i < 200 && mod_clk === 1'b1; i++) @(negedge clk_sys);
		while (mod_clk === 1'b0 && lo < 200) begin
			lo++;
			@(negedge clk_sys);
		end
		while (mod_clk === 1'b1 && hi < 200) begin
			hi++;
			@(negedge clk_sys);
		end
		chk("mod_clk high", 16'(hi), 16'd50, 0);
		chk("mod_clk low", 16'(lo), 16'd50, 0);
		$display("test reset_clock done");
	endtask

	// Steady angle; frame spacing of loads
	task automatic test_angle();
		set_angle(45.0);
		repeat (3) wait_load();
		chk("load spacing", 16'(gap), 16'd12800, 0);
		check_out(45.0);
		$display("test angle done");
	endtask

	// Step to a wide angle; time to settle
	task automatic test_step();
		int t0;
		int d;
		bit settled;
		settled = 1'b0;
		set_angle(150.0);
		t0 = cyc;
		// One load more than the bound allows, so a slow chain is caught
		for (int k = 0; k < 5 && !settled; k++) begin
			wait_load();
			d = int'(dac_code) - exp_code(150.0);
			settled = (d <= 12 && d >= -12);
		end
		chk("settle cycles ok", 16'(settled && (t_load - t0 <= 60000)), 16'h0001, 0);
		check_out(150.0);
		$display("test step done");
	endtask

	// Reset in mid-run, then no signal
	task automatic test_reset_lost();
		@(posedge clk_sys);
		#2;
		arst_n = 1'b0;
		sin_lvl = 16'sh0000;
		cos_lvl = 16'sh0000;
		repeat (5) @(negedge clk_sys);
		chk("reset dac_code", 16'(dac_code), 16'h0000, 0);
		chk("reset tobs", 16'(tobs), 16'h0000, 0);
		chk("reset lost", 16'(lost_signal), 16'h0000, 0);
		@(posedge clk_sys);
		#2;
		arst_n = 1'b1;
		t_load = cyc;
		wait_load();
		chk("lost dac_code", 16'(dac_code), 16'h0000, 0);
		chk("lost_signal", 16'(lost_signal), 16'h0001, 0);
		$display("test reset_lost done");
	endtask

	// Main sequence
	initial begin
		arst_n = 1'b0;
		sin_lvl = 16'sh0000;
		cos_lvl = 16'sh0000;
		repeat (3) @(posedge clk_sys);
		test_reset_clock();
		test_angle();
		test_step();
		test_reset_lost();
		give_verdict();
	end
endmodule
`default_nettype wire

// file: verilog/dca_decim.sv
// Third-order comb-integrator decimator for one single-bit stream.
// Assumes bit_en marks a valid input bit and dec_en the last bit of a frame.
`timescale 1ns/1ns
`default_nettype none
module dca_decim (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	// Bit stream
	input  wire logic                bit_in,
	input  wire logic                bit_en,
	input  wire logic                dec_en,
	// Filtered word
	output logic signed [14:0]       word_o,
	output logic                     valid_o
);
	typedef struct packed {
		logic signed [2:0][23:0] integ;
		logic signed [2:0][23:0] dly;
		logic signed [14:0]      word;
		logic                    valid;
	} dca_dec_st_t;

	dca_dec_st_t st_ff;
	dca_dec_st_t nxt_st;

	// Integrate every bit, comb and decimate once per frame
	always_comb begin
		logic signed [23:0] c;
		logic signed [23:0] s;
		c = 24'sh000000;
		s = 24'sh000000;
		nxt_st = st_ff;
		nxt_st.valid = 1'b0;
		if (bit_en) begin
			nxt_st.integ[0] = st_ff.integ[0] + (bit_in ? 24'sh000001 : 24'shffffff);
			for (int k = 1; k < dca_pkg::ORDER; k++) begin
				nxt_st.integ[k] = st_ff.integ[k] + st_ff.integ[k-1];
			end
		end
		if (dec_en) begin
			c = nxt_st.integ[dca_pkg::ORDER-1];
			for (int k = 0; k < dca_pkg::ORDER; k++) begin
				nxt_st.dly[k] = c;
				c = c - st_ff.dly[k];
			end
			s = c >>> dca_pkg::OSR_LOG2;
			if (s > 24'sh003fff) begin
				nxt_st.word = 15'sh3fff;
			end else if (s < -24'sh004000) begin
				nxt_st.word = -15'sh4000;
			end else begin
				nxt_st.word = s[14:0];
			end
			nxt_st.valid = 1'b1;
		end
	end

	// State register, private to this channel
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign word_o  = st_ff.word;
	assign valid_o = st_ff.valid;

	property p_word_after_frame;
		@(posedge clk_sys) disable iff (!rst_n)
		dec_en |=> valid_o ##1 !valid_o;
	endproperty
	a_word_after_frame: assert property (p_word_after_frame) else $error("word not one pulse after frame");

	property p_valid_cause;
		@(posedge clk_sys) disable iff (!rst_n)
		valid_o |-> $past(dec_en);
	endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("word valid without frame end");
endmodule
`default_nettype wire

// file: verilog/dca_pkg.sv
// Package of shared constants for the dual-channel decimation and angle core.
// Assumes a single 50 MHz system clock and no software-visible registers.
package dca_pkg;

	// System clock and modulator bit rate
	localparam int unsigned SYS_CLK_HZ  = 50_000_000;
	localparam int unsigned BIT_RATE_HZ = 500_000;
	localparam int unsigned BIT_DIV     = SYS_CLK_HZ / BIT_RATE_HZ;
	localparam int unsigned BIT_HALF    = BIT_DIV / 2;

	// Decimation and word widths
	localparam int unsigned OSR      = 128;
	localparam int unsigned OSR_LOG2 = 7;
	localparam int unsigned WORD_W   = 15;
	localparam int unsigned ACC_W    = 24;
	localparam int unsigned ORDER    = 3;

	// Angle datapath
	localparam int unsigned ANGLE_W = 13;
	localparam int unsigned XY_W    = 18;
	localparam int unsigned Z_W     = 16;
	localparam int unsigned ITERS   = 14;
	localparam logic [15:0] Z_HALF  = 16'h8000;

	// Output code bands: 5 % .. 95 % for angles, 0 for irregular input
	localparam logic [12:0] CODE_LO   = 13'h019a;
	localparam logic [12:0] CODE_HI   = 13'h1e66;
	localparam logic [12:0] CODE_SPAN = 13'h1ccc;
	localparam logic [12:0] CODE_DIAG = 13'h0000;

	// Magnitude below which the magnet is taken as lost
	localparam logic [17:0] LOST_MAG_DEF = 18'h00b4b;

	// Response time bound, in ns, and its cycle count
	localparam longint unsigned RESP_MAX_NS  = 1_200_000;
	localparam longint unsigned CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
	localparam int unsigned     RESP_MAX_CYC = int'(RESP_MAX_NS / CLK_PERIOD_NS);

	// Controller states, Gray coded along the path
	typedef enum logic [1:0] {
		DCA_IDLE = 2'b00,
		DCA_PRE  = 2'b01,
		DCA_ITER = 2'b11,
		DCA_MAP  = 2'b10
	} dca_fsm_t;

	// Arctangent of 2^-i, one full turn being 2^16
	function automatic logic [15:0] dca_atan(input logic [3:0] i);
		logic [15:0] r;
		r = 16'h0000;
		unique case (i)
			4'h0: r = 16'h2000;
			4'h1: r = 16'h12e4;
			4'h2: r = 16'h09fb;
			4'h3: r = 16'h0511;
			4'h4: r = 16'h028b;
			4'h5: r = 16'h0146;
			4'h6: r = 16'h00a3;
			4'h7: r = 16'h0051;
			4'h8: r = 16'h0029;
			4'h9: r = 16'h0014;
			4'ha: r = 16'h000a;
			4'hb: r = 16'h0005;
			4'hc: r = 16'h0003;
			4'hd: r = 16'h0001;
			default: r = 16'h0000;
		endcase
		return r;
	endfunction

endpackage

// file: verilog/dca_top.sv
// Dual-channel decimation and arctangent angle core with output code mapping.
// Assumes two modulators clocked by mod_clk and an output converter taking dac_code.
// Notes on behaviour
// - Sine and cosine each have their own bit input and their own filter instance.
// - Each filter low-passes its stream and emits one word per 128 input bits.
// - Each filter word is 15 bits wide and comes at about 3.9 kHz.
// - Each word pair is turned into an angle by an iterative shift-and-add arctangent.
// - The angle is kept as a 13-bit word.
// - Each new angle result is handed to the output converter.
// - The angle covers a full turn, 360 degrees, of the measured quantity.
// - The reset input returns filters and angle logic to their initial state.
// - After an input step the output settles within 1.2 ms.
// - Valid angles map to codes between 5 % and 95 % of full scale.
// - The control logic derives modulator clock and filter strobes from the system clock.
`timescale 1ns/1ns
`default_nettype none
module dca_top #(
	parameter int unsigned  RESP_MAX_CYC = dca_pkg::RESP_MAX_CYC,
	parameter logic [17:0]  LOST_MAG_TH  = dca_pkg::LOST_MAG_DEF
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Modulator side
	input  wire logic        sin_bit,
	input  wire logic        cos_bit,
	output logic             mod_clk,
	// Output converter side
	output logic [12:0]      dac_code,
	output logic             dac_load,
	// Observation
	output logic [12:0]      test_observation_output,
	output logic             lost_signal
);
	typedef struct packed {
		logic [6:0]              div_cnt;
		logic                    mclk;
		logic [6:0]              bit_cnt;
		dca_pkg::dca_fsm_t       fsm;
		logic signed [17:0]      x;
		logic signed [17:0]      y;
		logic [15:0]             z;
		logic [3:0]              iter;
		logic signed [14:0]      sin_s;
		logic signed [14:0]      cos_s;
		logic [12:0]             angle;
		logic [12:0]             code;
		logic                    load;
		logic                    lost;
	} dca_st_t;

	dca_st_t            st_ff;
	dca_st_t            nxt_st;
	logic [1:0]         rst_sync_ff;
	logic               rst_n;
	logic               bit_tick;
	logic               dec_tick;
	logic signed [14:0] sin_word;
	logic signed [14:0] cos_word;
	logic               sin_valid;
	logic               cos_valid;

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// Bit and frame strobes from the divider
	assign bit_tick = (st_ff.div_cnt == 7'(dca_pkg::BIT_DIV - 1));
	assign dec_tick = bit_tick && (st_ff.bit_cnt == 7'(dca_pkg::OSR - 1));

	// One filter per channel
	dca_decim u_dec_sin (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.bit_in  (sin_bit),
		.bit_en  (bit_tick),
		.dec_en  (dec_tick),
		.word_o  (sin_word),
		.valid_o (sin_valid)
	);
	dca_decim u_dec_cos (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.bit_in  (cos_bit),
		.bit_en  (bit_tick),
		.dec_en  (dec_tick),
		.word_o  (cos_word),
		.valid_o (cos_valid)
	);

	// Control, arctangent iterations and output mapping
	always_comb begin
		logic signed [17:0] xs;
		logic signed [17:0] ys;
		logic [25:0]        prod;
		xs = st_ff.x >>> st_ff.iter;
		ys = st_ff.y >>> st_ff.iter;
		prod = 26'(st_ff.angle) * 26'(dca_pkg::CODE_SPAN);
		nxt_st = st_ff;
		nxt_st.load = 1'b0;
		nxt_st.div_cnt = bit_tick ? 7'h00 : st_ff.div_cnt + 7'h01;
		nxt_st.mclk = (nxt_st.div_cnt < 7'(dca_pkg::BIT_HALF));
		if (bit_tick) begin
			nxt_st.bit_cnt = st_ff.bit_cnt + 7'h01;
		end
		unique case (st_ff.fsm)
			dca_pkg::DCA_IDLE: begin
				if (sin_valid && cos_valid) begin
					nxt_st.sin_s = sin_word;
					nxt_st.cos_s = cos_word;
					nxt_st.fsm = dca_pkg::DCA_PRE;
				end
			end
			dca_pkg::DCA_PRE: begin
				// Left half plane is turned by half a turn first
				if (st_ff.cos_s < 0) begin
					nxt_st.x = -18'(st_ff.cos_s);
					nxt_st.y = -18'(st_ff.sin_s);
					nxt_st.z = dca_pkg::Z_HALF;
				end else begin
					nxt_st.x = 18'(st_ff.cos_s);
					nxt_st.y = 18'(st_ff.sin_s);
					nxt_st.z = 16'h0000;
				end
				nxt_st.iter = 4'h0;
				nxt_st.fsm = dca_pkg::DCA_ITER;
			end
			dca_pkg::DCA_ITER: begin
				// Drive y toward zero, summing the turned angle
				if (st_ff.y >= 0) begin
					nxt_st.x = st_ff.x + ys;
					nxt_st.y = st_ff.y - xs;
					nxt_st.z = st_ff.z + dca_pkg::dca_atan(st_ff.iter);
				end else begin
					nxt_st.x = st_ff.x - ys;
					nxt_st.y = st_ff.y + xs;
					nxt_st.z = st_ff.z - dca_pkg::dca_atan(st_ff.iter);
				end
				nxt_st.iter = st_ff.iter + 4'h1;
				if (st_ff.iter == 4'(dca_pkg::ITERS - 1)) begin
					nxt_st.fsm = dca_pkg::DCA_MAP;
				end
			end
			dca_pkg::DCA_MAP: begin
				nxt_st.angle = st_ff.z[15:3];
				nxt_st.lost = (st_ff.x < $signed(LOST_MAG_TH));
				nxt_st.fsm = dca_pkg::DCA_IDLE;
			end
		endcase
		// Code and load pulse leave together with the angle word as the map step ends
		if (st_ff.fsm == dca_pkg::DCA_MAP) begin
			nxt_st.load = 1'b1;
			prod = 26'(st_ff.z[15:3]) * 26'(dca_pkg::CODE_SPAN);
			if (st_ff.x < $signed(LOST_MAG_TH)) begin
				nxt_st.code = dca_pkg::CODE_DIAG;
			end else begin
				nxt_st.code = dca_pkg::CODE_LO + prod[25:13];
			end
		end
	end

	// Single state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign mod_clk                 = st_ff.mclk;
	assign dac_code                = st_ff.code;
	assign dac_load                = st_ff.load;
	assign test_observation_output = st_ff.angle;
	assign lost_signal             = st_ff.lost;

	// Helper counters for the checks below
	logic [7:0]  chk_bits_ff;
	logic [31:0] chk_gap_ff;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			chk_bits_ff <= 8'h00;
			chk_gap_ff  <= 32'h0;
		end else begin
			chk_bits_ff <= dec_tick ? 8'h00 : chk_bits_ff + 8'(bit_tick);
			chk_gap_ff  <= dac_load ? 32'h0 : chk_gap_ff + 32'h1;
		end
	end

	property p_bit_period;
		@(posedge clk_sys) disable iff (!rst_n)
		bit_tick |-> ##100 bit_tick;
	endproperty
	a_bit_period: assert property (p_bit_period) else $error("bit tick period wrong");

	property p_frame_bits;
		@(posedge clk_sys) disable iff (!rst_n)
		dec_tick |-> chk_bits_ff == 8'(dca_pkg::OSR - 1);
	endproperty
	a_frame_bits: assert property (p_frame_bits) else $error("frame is not 128 bits");

	property p_iter_run;
		@(posedge clk_sys) disable iff (!rst_n)
		st_ff.fsm == dca_pkg::DCA_PRE |=> (st_ff.fsm == dca_pkg::DCA_ITER)[*8];
	endproperty
	a_iter_run: assert property (p_iter_run) else $error("iterations cut short");

	property p_calc_time;
		@(posedge clk_sys) disable iff (!rst_n)
		(sin_valid && st_ff.fsm == dca_pkg::DCA_IDLE) |-> ##[17:17] dac_load;
	endproperty
	a_calc_time: assert property (p_calc_time) else $error("angle not ready in time");

	property p_load_code;
		@(posedge clk_sys) disable iff (!rst_n)
		$changed(dac_code) |-> dac_load;
	endproperty
	a_load_code: assert property (p_load_code) else $error("code changed without load");

	property p_valid_band;
		@(posedge clk_sys) disable iff (!rst_n)
		(dac_load && !$past(st_ff.x < $signed(LOST_MAG_TH)))
			|-> (dac_code >= dca_pkg::CODE_LO && dac_code <= dca_pkg::CODE_HI);
	endproperty
	a_valid_band: assert property (p_valid_band) else $error("valid code outside band");

	property p_diag_band;
		@(posedge clk_sys) disable iff (!rst_n)
		##1 (dac_load && $past(st_ff.x < $signed(LOST_MAG_TH))) |-> dac_code == dca_pkg::CODE_DIAG;
	endproperty
	a_diag_band: assert property (p_diag_band) else $error("lost input not flagged");

	property p_half_span;
		@(posedge clk_sys) disable iff (!rst_n)
		(st_ff.fsm == dca_pkg::DCA_MAP && st_ff.sin_s > 15'sh0040 && st_ff.cos_s > 15'sh0040)
			|=> !st_ff.angle[12];
	endproperty
	a_half_span: assert property (p_half_span) else $error("angle quadrant wrong");

	property p_resp;
		@(posedge clk_sys) disable iff (!rst_n)
		chk_gap_ff <= 32'(RESP_MAX_CYC);
	endproperty
	a_resp: assert property (p_resp) else $error("output not refreshed in time");

	property p_reset_state;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(rst_n) |-> (st_ff.fsm == dca_pkg::DCA_IDLE && dac_code == 13'h0000 && !dac_load);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("state not cleared by reset");
endmodule
`default_nettype wire
